// *** nuf_close_acc.sv ***
module nuf_close_acc
  import nuf_pkg::*;
(
  input  wire logic               i_mclk,
  input  wire logic               i_resetn,
  input  wire logic               i_frame_strobe,
  input  wire logic               i_use_const,
  input  wire logic               i_band_valid,
  input  wire logic        [4:0]  i_band_idx,
  input  wire logic signed [23:0] i_band_log,
  input  wire logic signed [23:0] i_noise_log,
  output logic             [27:0] o_sum
);
  logic        [27:0] sum_reg;
  logic        [27:0] sum_next;
  logic signed [24:0] diff;

  // ------------------------------------------------------------
  // subband closeness sum
  // ------------------------------------------------------------
  always_comb
  begin
    diff = 25'(i_band_log) - (i_use_const ? 25'(LOG_EMIN) : 25'(i_noise_log));
    if (diff < 0)
      diff = -diff;
    sum_next = sum_reg;
    if (i_frame_strobe)
      sum_next = '0;
    else if (i_band_valid && i_band_idx >= SB_FIRST && i_band_idx <= SB_LAST)
      sum_next = sum_reg + 28'(unsigned'(diff));
  end

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
      sum_reg <= '0;
    else
      sum_reg <= sum_next;
  end

  assign o_sum = sum_reg;
endmodule

// *** nuf_hf_acc.sv ***
module nuf_hf_acc
  import nuf_pkg::*;
(
  input  wire logic               i_mclk,
  input  wire logic               i_resetn,
  input  wire logic               i_frame_strobe,
  input  wire logic               i_bin_valid,
  input  wire logic        [7:0]  i_bin_idx,
  input  wire logic signed [15:0] i_bin_value,
  output logic signed      [21:0] o_sum
);
  logic signed [21:0] sum_reg;
  logic signed [21:0] sum_next;

  // ------------------------------------------------------------
  // sum of the top residual bins
  // ------------------------------------------------------------
  always_comb
  begin
    sum_next = sum_reg;
    if (i_frame_strobe)
      sum_next = '0;
    else if (i_bin_valid && i_bin_idx >= HF_FIRST_BIN && i_bin_idx <= BIN_LAST)
      sum_next = sum_reg + 22'(i_bin_value);
  end

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
      sum_reg <= '0;
    else
      sum_reg <= sum_next;
  end

  assign o_sum = sum_reg;
endmodule

// *** nuf_pkg.sv ***
package nuf_pkg;
  // ------------------------------------------------------------
  // register map (apb byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_HF       = 8'h08;
  localparam logic [7:0] ADDR_HARM     = 8'h0c;
  localparam logic [7:0] ADDR_PAUSE    = 8'h10;
  localparam logic [7:0] ADDR_CLOSE    = 8'h14;
  localparam logic [7:0] ADDR_INIT     = 8'h18;
  localparam int         CTRL_WB_BIT   = 0;
  localparam logic       CTRL_WB_RST   = 1'b1;
  localparam int         ST_FLAG_BIT   = 4;
  localparam int         ST_OK_BIT     = 5;
  localparam int         ST_TONAL_BIT  = 6;
  // ------------------------------------------------------------
  // spectrum and subband layout
  // ------------------------------------------------------------
  localparam logic [7:0] BIN_LAST      = 8'h7f;
  localparam logic [7:0] HF_FIRST_BIN  = 8'h58;
  localparam logic [4:0] SB_FIRST      = 5'h02;
  localparam logic [4:0] SB_LAST       = 5'h10;
  // ------------------------------------------------------------
  // fixed point constants (q8.8 levels, q0.16 factors, plain counts)
  // ------------------------------------------------------------
  localparam logic signed [17:0] K_HF_OLD   = 18'sh0b333;
  localparam logic signed [17:0] K_HF_NEW   = 18'sh001ec;
  localparam logic signed [15:0] HF_LOW     = 16'sh099a;
  localparam logic signed [15:0] HF_DELTA   = 16'sh0480;
  localparam logic signed [23:0] LOG_EMIN   = 24'sh00000e;
  localparam logic        [2:0]  HOLD_INIT  = 3'h6;
  localparam logic        [2:0]  HOLD_MAX   = 3'h6;
  localparam logic        [2:0]  HOLD_UP    = 3'h2;
  localparam logic        [7:0]  INI_DONE   = 8'h64;
  localparam logic        [7:0]  INI_EARLY  = 8'h0a;
  localparam logic        [16:0] CORR_EVT   = 17'h0d99a;
  localparam logic signed [16:0] E_LOW      = 17'sh00f00;
  localparam logic signed [16:0] E_JUMP     = 17'sh00700;
  localparam logic signed [16:0] E_HIGH     = 17'sh01e00;
  localparam logic signed [16:0] VAR_HIGH   = 17'sh00800;
  localparam logic signed [16:0] E_PAUSE    = 17'sh00500;
  localparam logic        [15:0] K_RATE_UP  = 16'h07ae;
  localparam logic        [15:0] K_RATE_DN  = 16'h028f;
  localparam logic signed [15:0] PAUSE_ACT  = 16'shffff;
  localparam logic signed [15:0] PAUSE_MAX  = 16'sh7fff;
  // ------------------------------------------------------------
  // bandwidth thresholds
  // ------------------------------------------------------------
  localparam logic [19:0] STA_WB   = 20'h5573_0;
  localparam logic [19:0] STA_NB   = 20'h7a12_0;
  localparam logic [15:0] CORR_WB  = 16'h6ccd;
  localparam logic [15:0] CORR_NB  = 16'h599a;
  localparam logic [15:0] RESID_WB = 16'h019a;
  localparam logic [15:0] RESID_NB = 16'h0a66;
endpackage

// *** nuf_tracker.sv ***
// What this block does
// - high band level is 0.7 old plus 0.3 mean of last forty bins
// - level below 9.6 dB with flag set clears flag, stores reference
// - otherwise flag sets when level beats reference by over 4.5 dB
// - hold starts at six, plus two active, minus one inactive, within 0..6
// - thresholds chosen by wideband or narrowband setting
// - without increment the hold drops by one each frame
// - hold at zero signals noise update allowed
// - during first hundred frames closeness uses constant reference, subbands 2..16
// - after init closeness uses previous noise estimate, any bandwidth
// - harmonic counter clears on strong correlation or tonal frame, else counts
// - counter capped to one on low energy or on energy jump after the early frames
// - loud varying frames quarter the counter, minimum one
// - event rate moves toward one by 0.03 or toward zero by 0.01
// - pause counter starts at zero, goes to minus one on energy rise
// - energy back near minimum returns pause counter to zero
// - pause counter counts up last whenever nonnegative and below its maximum
// - tonal flag from correlation map sum over threshold or strong peak
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
module nuf_tracker
  import nuf_pkg::*;
(
  input  wire logic               i_mclk,
  input  wire logic               i_resetn,
  input  wire logic               i_psel,
  input  wire logic               i_penable,
  input  wire logic               i_pwrite,
  input  wire logic        [7:0]  i_paddr,
  input  wire logic        [31:0] i_pwdata,
  output logic                    o_pready,
  output logic             [31:0] o_prdata,
  output logic                    o_pslverr,
  input  wire logic               i_frame_strobe,
  input  wire logic               i_active_frame,
  input  wire logic               i_bin_valid,
  input  wire logic        [7:0]  i_bin_idx,
  input  wire logic signed [15:0] i_bin_value,
  input  wire logic               i_band_valid,
  input  wire logic        [4:0]  i_band_idx,
  input  wire logic signed [23:0] i_band_log,
  input  wire logic signed [23:0] i_noise_log,
  input  wire logic        [15:0] i_corr_norm0,
  input  wire logic        [15:0] i_corr_norm1,
  input  wire logic signed [15:0] i_corr_map_sum,
  input  wire logic signed [15:0] i_tonal_threshold,
  input  wire logic               i_strong_peak,
  input  wire logic signed [15:0] i_frame_energy,
  input  wire logic signed [15:0] i_long_term_energy,
  input  wire logic signed [15:0] i_energy_variance,
  input  wire logic signed [15:0] i_long_term_min_energy,
  output logic signed      [15:0] o_hf_dynamic_level,
  output logic                    o_hf_range_flag,
  output logic             [2:0]  o_hold_state,
  output logic                    o_noise_update_ok,
  output logic             [19:0] o_stationarity_threshold,
  output logic             [15:0] o_correlation_threshold,
  output logic             [15:0] o_residual_threshold,
  output logic             [27:0] o_closeness,
  output logic             [15:0] o_harmonic_count,
  output logic             [15:0] o_harmonic_event_rate,
  output logic signed      [15:0] o_pause_counter
);
  logic signed [21:0] hf_sum;
  logic        [27:0] close_sum;
  logic signed [15:0] hf_reg,    hf_next,    ref_reg,   ref_next;
  logic               flag_reg,  flag_next,  tonal_reg, tonal_next;
  logic        [2:0]  hold_reg,  hold_next;
  logic        [7:0]  ini_reg,   ini_next;
  logic        [15:0] harm_reg,  harm_next,  rate_reg,  rate_next;
  logic signed [15:0] pause_reg, pause_next;
  logic        [27:0] close_reg, close_next;
  logic               wb_reg,    wb_next,    ok_reg,    ok_next;
  logic        [19:0] sta_reg,   sta_next;
  logic        [15:0] corr_reg,  corr_next,  resid_reg, resid_next;
  logic               rdy_reg,   rdy_next,   err_reg,   err_next;
  logic        [31:0] rd_reg,    rd_next;
  logic signed [39:0] hf_prod;
  logic signed [16:0] d_lt,      d_min,      e_ext;
  logic        [31:0] rate_prod;
  logic               harm_evt,  ini_lt;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] sat_inc16(input logic [15:0] v);
    sat_inc16 = (v == 16'hffff) ? v : v + 16'h0001;
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_HF)
           || (a == ADDR_HARM) || (a == ADDR_PAUSE) || (a == ADDR_CLOSE)
           || (a == ADDR_INIT);
  endfunction

  // ------------------------------------------------------------
  // stream accumulators
  // ------------------------------------------------------------
  assign ini_lt = ini_reg < INI_DONE;

  nuf_hf_acc u_hf_acc (
    .i_mclk         (i_mclk),
    .i_resetn       (i_resetn),
    .i_frame_strobe (i_frame_strobe),
    .i_bin_valid    (i_bin_valid),
    .i_bin_idx      (i_bin_idx),
    .i_bin_value    (i_bin_value),
    .o_sum          (hf_sum)
  );

  nuf_close_acc u_close_acc (
    .i_mclk         (i_mclk),
    .i_resetn       (i_resetn),
    .i_frame_strobe (i_frame_strobe),
    .i_use_const    (ini_lt),
    .i_band_valid   (i_band_valid),
    .i_band_idx     (i_band_idx),
    .i_band_log     (i_band_log),
    .i_noise_log    (i_noise_log),
    .o_sum          (close_sum)
  );

  // ------------------------------------------------------------
  // per frame state
  // ------------------------------------------------------------
  always_comb
  begin
    hf_next    = hf_reg;
    ref_next   = ref_reg;
    flag_next  = flag_reg;
    tonal_next = tonal_reg;
    hold_next  = hold_reg;
    ini_next   = ini_reg;
    harm_next  = harm_reg;
    rate_next  = rate_reg;
    pause_next = pause_reg;
    close_next = close_reg;
    e_ext      = 17'(i_frame_energy);
    d_lt       = e_ext - 17'(i_long_term_energy);
    d_min      = e_ext - 17'(i_long_term_min_energy);
    hf_prod    = 40'(hf_reg) * 40'(K_HF_OLD) + 40'(hf_sum) * 40'(K_HF_NEW);
    harm_evt   = (i_corr_map_sum > i_tonal_threshold) || i_strong_peak;
    rate_prod  = '0;
    if (i_frame_strobe)
    begin
      hf_next    = hf_prod[31:16];
      tonal_next = harm_evt;
      if (hf_next < HF_LOW && flag_reg)
      begin
        flag_next = 1'b0;
        ref_next  = hf_next;
      end
      else if (17'(hf_next) - 17'(ref_reg) > 17'(HF_DELTA))
        flag_next = 1'b1;
      if (i_active_frame)
        hold_next = (hold_reg > HOLD_MAX - HOLD_UP) ? HOLD_MAX : hold_reg + HOLD_UP;
      else if (hold_reg != 3'h0)
        hold_next = hold_reg - 3'h1;
      close_next = close_sum;
      ini_next   = (ini_reg == 8'hff) ? ini_reg : ini_reg + 8'h01;
      if (17'(i_corr_norm0) + 17'(i_corr_norm1) > CORR_EVT || harm_evt)
        harm_next = '0;
      else
        harm_next = sat_inc16(harm_reg);
      if (harm_next > 16'h0001
          && (e_ext < E_LOW || (ini_reg > INI_EARLY && d_lt > E_JUMP)))
        harm_next = 16'h0001;
      if (harm_next > 16'h0001 && e_ext > E_HIGH && 17'(i_energy_variance) > VAR_HIGH)
        harm_next = (harm_next < 16'h0004) ? 16'h0001 : harm_next >> 2;
      if (harm_next == 16'h0000)
      begin
        rate_prod = 32'(16'hffff - rate_reg) * 32'(K_RATE_UP);
        rate_next = rate_reg + rate_prod[31:16];
      end
      else
      begin
        rate_prod = 32'(rate_reg) * 32'(K_RATE_DN);
        rate_next = rate_reg - rate_prod[31:16];
      end
      if (pause_next >= 0 && d_min > E_PAUSE)
        pause_next = PAUSE_ACT;
      if (pause_next == PAUSE_ACT && d_min < E_PAUSE)
        pause_next = '0;
      if (pause_next >= 0 && pause_next != PAUSE_MAX)
        pause_next = pause_next + 16'sh0001;
    end
    ok_next = (hold_next == 3'h0);
  end

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      hf_reg    <= '0;
      ref_reg   <= '0;
      flag_reg  <= 1'b0;
      tonal_reg <= 1'b0;
      hold_reg  <= HOLD_INIT;
      ok_reg    <= 1'b0;
      ini_reg   <= '0;
      harm_reg  <= '0;
      rate_reg  <= '0;
      pause_reg <= '0;
      close_reg <= '0;
    end
    else
    begin
      hf_reg    <= hf_next;
      ref_reg   <= ref_next;
      flag_reg  <= flag_next;
      tonal_reg <= tonal_next;
      hold_reg  <= hold_next;
      ok_reg    <= ok_next;
      ini_reg   <= ini_next;
      harm_reg  <= harm_next;
      rate_reg  <= rate_next;
      pause_reg <= pause_next;
      close_reg <= close_next;
    end
  end

  // ------------------------------------------------------------
  // apb slave and thresholds
  // ------------------------------------------------------------
  always_comb
  begin
    wb_next  = wb_reg;
    rdy_next = i_psel && !i_penable;
    err_next = i_psel && !i_penable && !addr_ok(i_paddr);
    rd_next  = rd_reg;
    if (i_psel && i_penable && rdy_reg && i_pwrite && i_paddr == ADDR_CTRL)
      wb_next = i_pwdata[CTRL_WB_BIT];
    if (i_psel && !i_penable)
    begin
      rd_next = '0;
      if (!i_pwrite)
        case (i_paddr)
          ADDR_CTRL:   rd_next[CTRL_WB_BIT] = wb_reg;
          ADDR_STATUS:
          begin
            rd_next[2:0]          = hold_reg;
            rd_next[ST_FLAG_BIT]  = flag_reg;
            rd_next[ST_OK_BIT]    = ok_reg;
            rd_next[ST_TONAL_BIT] = tonal_reg;
          end
          ADDR_HF:     rd_next = {ref_reg, hf_reg};
          ADDR_HARM:   rd_next = {rate_reg, harm_reg};
          ADDR_PAUSE:  rd_next = 32'(pause_reg);
          ADDR_CLOSE:  rd_next = 32'(close_reg);
          ADDR_INIT:   rd_next = 32'(ini_reg);
          default:     rd_next = '0;
        endcase
    end
    sta_next   = wb_reg ? STA_WB : STA_NB;
    corr_next  = wb_reg ? CORR_WB : CORR_NB;
    resid_next = wb_reg ? RESID_WB : RESID_NB;
  end

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wb_reg    <= CTRL_WB_RST;
      rdy_reg   <= 1'b0;
      err_reg   <= 1'b0;
      rd_reg    <= '0;
      sta_reg   <= STA_WB;
      corr_reg  <= CORR_WB;
      resid_reg <= RESID_WB;
    end
    else
    begin
      wb_reg    <= wb_next;
      rdy_reg   <= rdy_next;
      err_reg   <= err_next;
      rd_reg    <= rd_next;
      sta_reg   <= sta_next;
      corr_reg  <= corr_next;
      resid_reg <= resid_next;
    end
  end

  assign o_pready                 = rdy_reg;
  assign o_pslverr                = err_reg;
  assign o_prdata                 = rd_reg;
  assign o_hf_dynamic_level       = hf_reg;
  assign o_hf_range_flag          = flag_reg;
  assign o_hold_state             = hold_reg;
  assign o_noise_update_ok        = ok_reg;
  assign o_stationarity_threshold = sta_reg;
  assign o_correlation_threshold  = corr_reg;
  assign o_residual_threshold     = resid_reg;
  assign o_closeness              = close_reg;
  assign o_harmonic_count         = harm_reg;
  assign o_harmonic_event_rate    = rate_reg;
  assign o_pause_counter          = pause_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  sequence s_rise;
    i_frame_strobe && pause_reg >= 0 && d_min > E_PAUSE;
  endsequence

  property p_hf_clear;
    i_frame_strobe && hf_next < HF_LOW && flag_reg |=> !flag_reg && ref_reg == hf_reg;
  endproperty
  a_hf_clear: assert property (p_hf_clear) else $error("flag not cleared");

  property p_hf_keep;
    !i_frame_strobe |=> $stable(flag_reg) && $stable(ref_reg) && $stable(hf_reg);
  endproperty
  a_hf_keep: assert property (p_hf_keep) else $error("hf state moved");

  property p_hold_range;
    hold_reg <= HOLD_MAX;
  endproperty
  a_hold_range: assert property (p_hold_range) else $error("hold out of range");

  property p_hold_dec;
    i_frame_strobe && !i_active_frame && hold_reg != 3'h0 |=> hold_reg == $past(hold_reg) - 3'h1;
  endproperty
  a_hold_dec: assert property (p_hold_dec) else $error("hold not decremented");

  property p_update_ok;
    o_noise_update_ok == (hold_reg == 3'h0);
  endproperty
  a_update_ok: assert property (p_update_ok) else $error("update flag wrong");

  property p_thr;
    wb_reg |=> o_stationarity_threshold == STA_WB && o_residual_threshold == RESID_WB;
  endproperty
  a_thr: assert property (p_thr) else $error("wideband thresholds wrong");

  property p_harm_reset;
    i_frame_strobe && harm_evt |=> o_harmonic_count == 16'h0000;
  endproperty
  a_harm_reset: assert property (p_harm_reset) else $error("counter not cleared");

  property p_rate_up;
    i_frame_strobe && harm_next == 16'h0000 |=> rate_reg >= $past(rate_reg);
  endproperty
  a_rate_up: assert property (p_rate_up) else $error("rate fell on event");

  property p_pause_act;
    s_rise |=> pause_reg == PAUSE_ACT;
  endproperty
  a_pause_act: assert property (p_pause_act) else $error("pause not active");

  property p_pause_inc;
    i_frame_strobe && pause_reg >= 0 && pause_reg != PAUSE_MAX && !(d_min > E_PAUSE)
      |=> pause_reg == $past(pause_reg) + 16'sh0001;
  endproperty
  a_pause_inc: assert property (p_pause_inc) else $error("pause not counted");
endmodule

// *** nuf_upstream.sv ***
module nuf_upstream
(
  input  wire logic               i_mclk,
  input  wire logic               i_go,
  input  wire logic               i_stream,
  input  wire logic signed [15:0] i_bin_level,
  input  wire logic signed [23:0] i_band_level,
  input  wire logic signed [23:0] i_noise_level,
  output logic                    o_busy = 1'b0,
  output logic                    o_frame_strobe = 1'b0,
  output logic                    o_bin_valid = 1'b0,
  output logic             [7:0]  o_bin_idx = 8'h00,
  output logic signed      [15:0] o_bin_value = 16'sh0,
  output logic                    o_band_valid = 1'b0,
  output logic             [4:0]  o_band_idx = 5'h00,
  output logic signed      [23:0] o_band_log = 24'sh0,
  output logic signed      [23:0] o_noise_log = 24'sh0
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------
  // frame sequencer
  // --------------------
  // strobe after inputs
  always
  begin
    @(posedge i_mclk);
    if (i_go)
    begin
      o_busy <= 1'b1;
      for (int k = 0; k < 48 && i_stream; k++)
      begin
        o_bin_valid  <= 1'b1;
        o_bin_idx    <= 8'(k + 80);
        o_bin_value  <= (k < 8) ? 16'sh7f00 : i_bin_level;
        o_band_valid <= k < 15;
        o_band_idx   <= 5'(k + 2);
        o_band_log   <= (k < 15) ? i_band_level : ~i_band_level;
        o_noise_log  <= (k < 15) ? i_noise_level : ~i_noise_level;
        @(posedge i_mclk);
      end
      o_bin_valid    <= 1'b0;
      o_band_valid   <= 1'b0;
      o_bin_value    <= ~i_bin_level;
      o_band_log     <= ~i_band_level;
      o_noise_log    <= ~i_noise_level;
      o_frame_strobe <= 1'b1;
      @(posedge i_mclk);
      o_frame_strobe <= 1'b0;
      o_busy         <= 1'b0;
    end
  end
endmodule

// *** tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import nuf_pkg::*;
  // --------------------
  // signals and instances
  // --------------------
  logic i_mclk = 1'b0, i_resetn = 1'b0, i_psel = 1'b0, i_penable = 1'b0;
  logic i_pwrite = 1'b0, i_active_frame = 1'b0, i_strong_peak = 1'b0;
  logic [7:0] i_paddr = 8'h00, i_bin_idx;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
  logic [15:0] i_corr_norm0 = 16'h0, i_corr_norm1 = 16'h0, c0 = 16'h0, c1 = 16'h0;
  logic signed [15:0] i_frame_energy = 16'sh0, i_long_term_energy = 16'sh0, fe = 16'sh0;
  logic signed [15:0] i_energy_variance = 16'sh0, i_long_term_min_energy = 16'sh0;
  logic signed [15:0] i_corr_map_sum = 16'sh0, i_tonal_threshold = 16'sh3800, vr = 16'sh0;
  logic signed [15:0] lte = 16'sh0, lmin = 16'sh0, msum = 16'sh0, bin_lvl = 16'sh0;
  logic act = 1'b0, pk = 1'b0, go = 1'b0, strm = 1'b0, err, busy;
  logic i_frame_strobe, i_bin_valid, i_band_valid, o_pready, o_pslverr;
  logic o_hf_range_flag, o_noise_update_ok;
  logic [4:0] i_band_idx;
  logic signed [23:0] i_band_log, i_noise_log;
  logic signed [15:0] i_bin_value, o_hf_dynamic_level, o_pause_counter;
  logic [2:0] o_hold_state;
  logic [19:0] o_stationarity_threshold;
  logic [15:0] o_correlation_threshold, o_residual_threshold;
  logic [15:0] o_harmonic_count, o_harmonic_event_rate;
  logic [27:0] o_closeness;
  int n_errors = 0, compares = 0, cyc = 0, nfr = 0;
  always #50 i_mclk = ~i_mclk;
  nuf_tracker dut (.*);
  nuf_upstream up (.i_mclk(i_mclk), .i_go(go), .i_stream(strm), .i_bin_level(bin_lvl),
    .i_band_level(24'sd114), .i_noise_level(24'sd64), .o_busy(busy),
    .o_frame_strobe(i_frame_strobe), .o_bin_valid(i_bin_valid), .o_bin_idx(i_bin_idx),
    .o_bin_value(i_bin_value), .o_band_valid(i_band_valid), .o_band_idx(i_band_idx),
    .o_band_log(i_band_log), .o_noise_log(i_noise_log));
  // --------------------
  // tasks and sequence
  // --------------------
  task automatic wrap_up;
    if (n_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic near(input logic signed [31:0] got, input int exp);
    chk(32'(got >= exp - 3 && got <= exp + 3), 32'h1);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    do @(posedge i_mclk); while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic thr(input logic nb);
    repeat (2) @(negedge i_mclk);
    chk(o_stationarity_threshold, nb ? STA_NB : STA_WB);
    chk(o_correlation_threshold, nb ? CORR_NB : CORR_WB);
    chk(o_residual_threshold, nb ? RESID_NB : RESID_WB);
  endtask
  task automatic frame(input logic s);
    @(posedge i_mclk);
    i_active_frame <= act;
    i_frame_energy <= fe;
    i_long_term_energy <= lte;
    i_energy_variance <= vr;
    i_long_term_min_energy <= lmin;
    i_corr_norm0 <= c0;
    i_corr_norm1 <= c1;
    i_corr_map_sum <= msum;
    i_strong_peak <= pk;
    strm <= s;
    go <= 1'b1;
    @(posedge i_mclk);
    go <= 1'b0;
    do @(negedge i_mclk); while (busy !== 1'b0);
    nfr++;
  endtask
  task automatic rst;
    @(posedge i_mclk);
    i_resetn <= 1'b0;
    repeat (4) @(posedge i_mclk);
    i_resetn <= 1'b1;
    nfr = 0;
    thr(1'b0);
    chk(o_hold_state, 6);
    chk(o_noise_update_ok, 0);
    chk(o_pause_counter, 0);
    chk(o_closeness, 0);
    chk(o_hf_dynamic_level, 0);
  endtask
  task automatic t_apb;
    apb(1'b0, ADDR_CTRL, 0);
    chk(rd, 1);
    apb(1'b1, ADDR_CTRL, 0);
    thr(1'b1);
    apb(1'b0, 8'h1c, 0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, ADDR_CTRL, 1);
    thr(1'b0);
  endtask
  task automatic t_hold;
    for (int i = 5; i >= 0; i--)
    begin
      frame(1'b0);
      chk(o_hold_state, i);
    end
    chk(o_noise_update_ok, 1);
    frame(1'b0);
    chk(o_hold_state, 0);
    act = 1'b1;
    for (int i = 2; i <= 8; i += 2)
    begin
      frame(1'b0);
      chk(o_hold_state, (i > 6) ? 6 : i);
    end
    chk(o_noise_update_ok, 0);
    act = 1'b0;
  endtask
  task automatic t_pause;
    chk(o_pause_counter, nfr);
    lmin = 16'sh0100;
    fe = 16'sh0700;
    frame(1'b0);
    chk(o_pause_counter, -1);
    fe = 16'sh0600;
    frame(1'b0);
    chk(o_pause_counter, -1);
    fe = 16'sh0500;
    frame(1'b0);
    chk(o_pause_counter, 1);
  endtask
  task automatic hstep(input int exp);
    frame(1'b0);
    chk(o_harmonic_count, exp);
  endtask
  task automatic t_harm;
    fe = 16'sh2000;
    lte = 16'sh2000;
    c0 = 16'h7000;
    c1 = 16'h6e00;
    hstep(0);
    near(o_harmonic_event_rate, 1966);
    c0 = 16'h0;
    c1 = 16'h0;
    hstep(1);
    near(o_harmonic_event_rate, 1946);
    for (int i = 2; i < 10; i++)
      hstep(i);
    vr = 16'sh0900;
    hstep(2);
    hstep(1);
    vr = 16'sh0;
    fe = 16'sh0e00;
    hstep(1);
    fe = 16'sh2000;
    lte = 16'sh1000;
    hstep(1);
    lte = 16'sh1900;
    hstep(2);
    pk = 1'b1;
    hstep(0);
    apb(1'b0, ADDR_STATUS, 0);
    chk(rd[ST_TONAL_BIT], 1);
    pk = 1'b0;
    msum = 16'sh4000;
    hstep(0);
    msum = 16'sh3800;
    hstep(1);
  endtask
  task automatic t_hf;
    bin_lvl = 16'sh1400;
    frame(1'b1);
    near(o_hf_dynamic_level, 1536);
    chk(o_hf_range_flag, 1);
    chk(o_closeness, 1500);
    bin_lvl = 16'sh0;
    frame(1'b1);
    chk(o_hf_range_flag, 0);
    apb(1'b0, ADDR_HF, 0);
    near(rd[31:16], 1075);
    frame(1'b1);
    near(o_hf_dynamic_level, 753);
    chk(o_hf_range_flag, 0);
    apb(1'b0, ADDR_HF, 0);
    near(rd[31:16], 1075);
  endtask
  task automatic t_close;
    while (nfr < 100)
      frame(1'b0);
    apb(1'b1, ADDR_CTRL, 0);
    frame(1'b1);
    chk(o_closeness, 750);
  endtask
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      n_errors++;
      wrap_up;
    end
  end
  initial
  begin
    rst;
    t_apb;
    t_hold;
    t_pause;
    t_harm;
    t_hf;
    t_close;
    rst;
    wrap_up;
  end
endmodule
